// [design/iff_pkg.sv]
// Shared types and constants of the instruction format and flag unit.
package iff_pkg;
	localparam int         IFF_DATA_W      = 32;
	localparam int         IFF_MAX_WORDS   = 7;
	localparam int         IFF_ADDR_W      = 4;
	localparam logic [3:0] IFF_ADDR_FLAGS  = 4'h0;
	localparam logic [3:0] IFF_ADDR_DECODE = 4'h4;
	localparam logic [4:0] IFF_FLAGS_RESET = 5'h00;
	localparam int         IFF_FLAG_LSB    = 0;
	localparam logic [3:0] IFF_LINE_A      = 4'hA;
	localparam logic [3:0] IFF_LINE_F      = 4'hF;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} iff_size_type;

	typedef enum logic [3:0] {
		OP_NONE    = 4'b0000,
		OP_LOGIC   = 4'b0001,
		OP_ADD     = 4'b0010,
		OP_SUB     = 4'b0011,
		OP_CMP     = 4'b0100,
		OP_ADD_WITH_EXTEND_OP    = 4'b0101,
		OP_SUBTRACT_WITH_EXTEND_OP    = 4'b0110,
		OP_NEGATE_WITH_EXTEND_OP    = 4'b0111,
		OP_NEG     = 4'b1000,
		OP_DECIMAL = 4'b1001,
		OP_DIV     = 4'b1010,
		OP_MUL     = 4'b1011,
		OP_BOUNDS  = 4'b1100
	} iff_op_type;

	typedef enum logic [2:0] {
		EXT_NONE        = 3'b000,
		EXT_IMMEDIATE   = 3'b001,
		EXT_EA          = 3'b010,
		EXT_BRANCH      = 3'b011,
		EXT_BIT_NUMBER  = 3'b100,
		EXT_SPECIAL_REG = 3'b101,
		EXT_TRAP_OPER   = 3'b110,
		EXT_ARG_COUNT   = 3'b111
	} iff_ext_type;

	typedef enum logic [1:0] {
		LOC_REG_FIELD = 2'b00,
		LOC_EA_FIELD  = 2'b01,
		LOC_IMPLICIT  = 2'b10
	} iff_loc_type;

	typedef enum logic {
		AV_IDLE   = 1'b0,
		AV_ANSWER = 1'b1
	} iff_av_state_type;

	// Flag byte layout, carry in bit 0 up to extend in bit 4.
	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} iff_flags_type;

	typedef struct packed {
		logic [IFF_DATA_W-1:0] src;
		logic [IFF_DATA_W-1:0] dst;
		logic [IFF_DATA_W-1:0] res;
		logic [IFF_DATA_W-1:0] lower;
		logic [IFF_DATA_W-1:0] upper;
	} iff_operands_type;

	typedef struct packed {
		logic        reg_is_addr;
		logic [2:0]  reg_num;
		iff_loc_type loc;
		iff_ext_type ext;
		logic        trap;
		logic [2:0]  length;
	} iff_decode_type;
endpackage

// [design/iff_insn_decode.sv]
// Operation word decoder giving length, extension kind and operand place.
`timescale 1ns/1ps
module iff_insn_decode
	import iff_pkg::*;
(
	input  wire logic [15:0]    op_word,
	output iff_decode_type      info
);
	// Extension words that one effective address field needs.
	function automatic logic [2:0] ea_words(input logic [2:0] mode,
		input logic [2:0] rn, input logic [1:0] size);
		logic [2:0] w;
		w = 3'h0;
		if (mode == 3'h5 || mode == 3'h6)
			w = 3'h1;
		else if (mode == 3'h7)
		begin
			if (rn == 3'h1 || (rn == 3'h4 && size == SZ_LONG))
				w = 3'h2;
			else if (rn <= 3'h4)
				w = 3'h1;
		end
		return w;
	endfunction

	logic [3:0]  line;
	logic [3:0]  words;
	logic [1:0]  msize;

	// The operation word alone fixes operation and length.
	always_comb
	begin
		line = op_word[15:12];
		msize = (line == 4'h1) ? SZ_BYTE :
			(line == 4'h3) ? SZ_WORD : SZ_LONG;
		words = 4'h0;
		info = '0;
		info.loc = LOC_EA_FIELD;
		info.reg_num = op_word[11:9];
		if (line == IFF_LINE_A || line == IFF_LINE_F)
			info.trap = 1'b1;
		else if (line == 4'h0)
		begin
			if (op_word[11:8] == 4'h8)
				info.ext = EXT_BIT_NUMBER;
			else if (op_word[11:8] == 4'hE)
				info.ext = EXT_SPECIAL_REG;
			else if (!op_word[8])
				info.ext = EXT_IMMEDIATE;
			else
				info.loc = LOC_REG_FIELD;
			if (info.ext == EXT_IMMEDIATE && op_word[7:6] == SZ_LONG)
				words = 4'h2;
			else if (info.ext != EXT_NONE)
				words = 4'h1;
			words = words + {1'b0, ea_words(op_word[5:3], op_word[2:0],
				op_word[7:6])};
			// Words that only extend the address field are still extensions.
			if (info.ext == EXT_NONE)
				info.ext = EXT_EA;
		end
		else if (line <= 4'h3)
		begin
			words = {1'b0, ea_words(op_word[5:3], op_word[2:0], msize)}
				+ {1'b0, ea_words(op_word[8:6], op_word[11:9], msize)};
			info.ext = EXT_EA;
		end
		else if (line == 4'h5 && op_word[7:3] == 5'h1F)
		begin
			info.ext = EXT_TRAP_OPER;
			info.loc = LOC_IMPLICIT;
			words = (op_word[2:0] == 3'h3) ? 4'h2 :
				(op_word[2:0] == 3'h2) ? 4'h1 : 4'h0;
		end
		else if (line == 4'h5 && op_word[7:3] == 5'h19)
		begin
			info.ext = EXT_BRANCH;
			info.loc = LOC_REG_FIELD;
			info.reg_num = op_word[2:0];
			words = 4'h1;
		end
		else if (line == 4'h6)
		begin
			info.ext = EXT_BRANCH;
			info.loc = LOC_IMPLICIT;
			words = (op_word[7:0] == 8'hFF) ? 4'h2 :
				(op_word[7:0] == 8'h00) ? 4'h1 : 4'h0;
		end
		else if (line == 4'h7)
			info.loc = LOC_REG_FIELD;
		else
		begin
			if (line != 4'h4)
				info.loc = LOC_REG_FIELD;
			info.reg_is_addr = (line == 4'h9 || line == 4'hB ||
				line == 4'hD) && op_word[7:6] == 2'h3;
			info.ext = EXT_EA;
			words = {1'b0, ea_words(op_word[5:3], op_word[2:0],
				op_word[7:6])};
		end
		if (words == 4'h0)
			info.ext = EXT_NONE;
		// One word at least, clamped at seven in total.
		if (words >= 4'(IFF_MAX_WORDS - 1))
			info.length = 3'(IFF_MAX_WORDS);
		else
			info.length = words[2:0] + 3'h1;
	end
endmodule

// [design/iff_flag_unit.sv]
// Flag unit: flag byte update, instruction decode, register slave.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module iff_flag_unit
	import iff_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic [15:0]       op_word,
	input  wire logic              op_word_valid,
	input  wire logic              wb_valid,
	input  iff_op_type             wb_op,
	input  iff_size_type           wb_size,
	input  iff_operands_type       wb_operands,
	input  wire logic              wb_signed,
	input  wire logic [31:0]       wb_product_high,
	input  wire logic              wb_decimal_carry,
	input  wire logic              wb_div_overflow,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	output logic [7:0]             result_flag_byte,
	output iff_decode_type         decode_info,
	output logic                   decode_valid,
	output logic                   trap_request
);
	// Top bit of a value at the given operand size.
	function automatic logic op_msb(input logic [31:0] v,
		input logic [1:0] sz);
		return (sz == SZ_BYTE) ? v[7] : (sz == SZ_WORD) ? v[15] : v[31];
	endfunction

	// Every bit of the sized value is zero.
	function automatic logic op_zero(input logic [31:0] v,
		input logic [1:0] sz);
		return (sz == SZ_BYTE) ? (v[7:0] == 8'h00) :
			(sz == SZ_WORD) ? (v[15:0] == 16'h0000) : (v == 32'h0);
	endfunction

	// Sized value widened by sign or zero for bounds compares.
	function automatic logic signed [32:0] op_ext(input logic [31:0] v,
		input logic [1:0] sz, input logic sg);
		logic e;
		e = sg & op_msb(v, sz);
		if (sz == SZ_BYTE)
			return {{25{e}}, v[7:0]};
		else if (sz == SZ_WORD)
			return {{17{e}}, v[15:0]};
		return {e, v};
	endfunction

	iff_flags_type     flags_ff;
	iff_flags_type     nxt_flags;
	iff_decode_type    dec_comb;
	iff_decode_type    decode_ff;
	logic              decode_valid_ff;
	logic              trap_ff;
	iff_av_state_type  av_state_ff;
	logic [31:0]       readdata_ff;
	logic              waitreq_ff;
	logic              sm;
	logic              dm;
	logic              rm;
	logic              rz;
	logic              add_v;
	logic              add_c;
	logic              sub_v;
	logic              sub_c;
	logic              mul_ovf;
	logic signed [32:0] r_ext;
	logic signed [32:0] lb_ext;
	logic signed [32:0] ub_ext;
	logic              bnd_eq;
	logic              bnd_out;
	logic              sw_flag_wr;

	iff_insn_decode u_decode
	(
		.op_word (op_word),
		.info    (dec_comb)
	);

	// Sized top bits and the printed flag equations.
	always_comb
	begin
		sm = op_msb(wb_operands.src, wb_size);
		dm = op_msb(wb_operands.dst, wb_size);
		rm = op_msb(wb_operands.res, wb_size);
		rz = op_zero(wb_operands.res, wb_size);
		add_v = (sm & dm & ~rm) | (~sm & ~dm & rm);
		add_c = (sm & dm) | (~rm & dm) | (sm & ~rm);
		sub_v = (~sm & dm & ~rm) | (sm & ~dm & rm);
		sub_c = (sm & ~dm) | (rm & ~dm) | (sm & rm);
		// A long product overflows when its upper half is not
		// just the extension of the low half.
		if (wb_size != SZ_LONG)
			mul_ovf = 1'b0;
		else if (wb_signed)
			mul_ovf = wb_product_high != {32{wb_operands.res[31]}};
		else
			mul_ovf = wb_product_high != 32'h0;
		r_ext = op_ext(wb_operands.dst, wb_size, wb_signed);
		lb_ext = op_ext(wb_operands.lower, wb_size, wb_signed);
		ub_ext = op_ext(wb_operands.upper, wb_size, wb_signed);
		bnd_eq = (r_ext == lb_ext) || (r_ext == ub_ext);
		if (lb_ext <= ub_ext)
			bnd_out = (r_ext < lb_ext) || (r_ext > ub_ext);
		else
			bnd_out = (r_ext > ub_ext) && (r_ext < lb_ext);
	end

	// Next flag byte per operation row; undefined flags hold.
	always_comb
	begin
		nxt_flags = flags_ff;
		case (wb_op)
			OP_LOGIC:
			begin
				nxt_flags.n = rm;
				nxt_flags.z = rz;
				nxt_flags.v = 1'b0;
				nxt_flags.c = 1'b0;
			end
			OP_ADD, OP_ADD_WITH_EXTEND_OP:
			begin
				nxt_flags.n = rm;
				nxt_flags.v = add_v;
				nxt_flags.c = add_c;
				nxt_flags.x = add_c;
				nxt_flags.z = (wb_op == OP_ADD_WITH_EXTEND_OP) ? (flags_ff.z & rz) : rz;
			end
			OP_SUB, OP_SUBTRACT_WITH_EXTEND_OP, OP_CMP:
			begin
				nxt_flags.n = rm;
				nxt_flags.v = sub_v;
				nxt_flags.c = sub_c;
				if (wb_op != OP_CMP)
					nxt_flags.x = sub_c;
				nxt_flags.z = (wb_op == OP_SUBTRACT_WITH_EXTEND_OP) ? (flags_ff.z & rz) : rz;
			end
			OP_NEG, OP_NEGATE_WITH_EXTEND_OP:
			begin
				nxt_flags.n = rm;
				nxt_flags.v = dm & rm;
				nxt_flags.c = dm | rm;
				nxt_flags.x = dm | rm;
				nxt_flags.z = (wb_op == OP_NEGATE_WITH_EXTEND_OP) ? (flags_ff.z & rz) : rz;
			end
			OP_DECIMAL:
			begin
				nxt_flags.c = wb_decimal_carry;
				nxt_flags.x = wb_decimal_carry;
				nxt_flags.z = flags_ff.z & rz;
			end
			OP_DIV:
			begin
				nxt_flags.n = rm;
				nxt_flags.z = rz;
				nxt_flags.v = wb_div_overflow;
				nxt_flags.c = 1'b0;
			end
			OP_MUL:
			begin
				nxt_flags.n = rm;
				nxt_flags.z = rz;
				nxt_flags.v = mul_ovf;
				nxt_flags.c = 1'b0;
			end
			OP_BOUNDS:
			begin
				nxt_flags.z = bnd_eq;
				nxt_flags.c = bnd_out;
			end
			default:
				nxt_flags = flags_ff;
		endcase
	end

	assign sw_flag_wr = avs_write && av_state_ff == AV_ANSWER &&
		avs_address == IFF_ADDR_FLAGS && avs_byteenable[0];

	// Flag byte; writeback wins over a software write.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			flags_ff <= IFF_FLAGS_RESET;
		else if (wb_valid)
			flags_ff <= nxt_flags;
		else if (sw_flag_wr)
			flags_ff <= avs_writedata[IFF_FLAG_LSB +: 5];
	end

	// Registered decode of each operation word offered.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			decode_ff <= '0;
			decode_valid_ff <= 1'b0;
			trap_ff <= 1'b0;
		end
		else
		begin
			decode_valid_ff <= op_word_valid;
			trap_ff <= op_word_valid && dec_comb.trap;
			if (op_word_valid)
				decode_ff <= dec_comb;
		end
	end

	// Bus slave: one wait cycle, then a single answer cycle.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			av_state_ff <= AV_IDLE;
			readdata_ff <= 32'h0;
			waitreq_ff <= 1'b1;
		end
		else
		begin
			case (av_state_ff)
				AV_IDLE:
				begin
					if (avs_read || avs_write)
					begin
						av_state_ff <= AV_ANSWER;
						waitreq_ff <= 1'b0;
					end
					if (avs_read && avs_address == IFF_ADDR_FLAGS)
						readdata_ff <= {27'h0, flags_ff};
					else if (avs_read && avs_address == IFF_ADDR_DECODE)
						readdata_ff <= {19'h0, decode_ff};
					else
						readdata_ff <= 32'h0;
				end
				default:
				begin
					av_state_ff <= AV_IDLE;
					waitreq_ff <= 1'b1;
				end
			endcase
		end
	end

	assign avs_readdata = readdata_ff;
	assign avs_waitrequest = waitreq_ff;
	assign result_flag_byte = {3'h0, flags_ff};
	assign decode_info = decode_ff;
	assign decode_valid = decode_valid_ff;
	assign trap_request = trap_ff;

	// Logic rows clear overflow and carry, keep extend.
	property p_logic_clear;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_LOGIC |=> !flags_ff.v && !flags_ff.c
			&& flags_ff.x == $past(flags_ff.x);
	endproperty
	a_logic_clear: assert property (p_logic_clear)
		else $error("logic op left overflow or carry set");

	// Compare, divide, multiply and bounds keep extend.
	property p_x_kept;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && (wb_op == OP_CMP || wb_op == OP_DIV ||
			wb_op == OP_MUL || wb_op == OP_BOUNDS) |=> $stable(flags_ff.x);
	endproperty
	a_x_kept: assert property (p_x_kept)
		else $error("extend changed by an op that keeps it");

	// Add: extend equals the new carry.
	property p_add_x;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_ADD |=> flags_ff.x == flags_ff.c
			&& flags_ff.c == $past(add_c) && flags_ff.n == $past(rm);
	endproperty
	a_add_x: assert property (p_add_x)
		else $error("add carry or extend wrong");

	// Subtract copies borrow to extend.
	property p_sub_x;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_SUB |=> flags_ff.x == flags_ff.c
			&& flags_ff.v == $past(sub_v);
	endproperty
	a_sub_x: assert property (p_sub_x)
		else $error("subtract borrow not copied to extend");

	// Extended chain: zero result never sets zero.
	property p_chain_zero;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && (wb_op == OP_ADD_WITH_EXTEND_OP || wb_op == OP_SUBTRACT_WITH_EXTEND_OP ||
			wb_op == OP_NEGATE_WITH_EXTEND_OP) && rz && !flags_ff.z |=> !flags_ff.z;
	endproperty
	a_chain_zero: assert property (p_chain_zero)
		else $error("extended op set zero flag");

	// Decimal: carry and extend follow decimal carry.
	property p_decimal;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_DECIMAL |=> flags_ff.c ==
			$past(wb_decimal_carry) && flags_ff.x == flags_ff.c
			&& (!flags_ff.z || $past(flags_ff.z));
	endproperty
	a_decimal: assert property (p_decimal)
		else $error("decimal op flags wrong");

	// Divide clears carry and reports overflow.
	property p_div;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_DIV |=> !flags_ff.c
			&& flags_ff.v == $past(wb_div_overflow);
	endproperty
	a_div: assert property (p_div)
		else $error("divide flags wrong");

	// Unsigned long multiply with upper bits set overflows.
	property p_mul;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_MUL && !wb_signed && wb_size == SZ_LONG
			&& wb_product_high != 32'h0 |=> flags_ff.v && !flags_ff.c;
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply overflow missed");

	// Bounds equal to a limit sets zero and clears carry.
	property p_bounds;
		@(posedge sys_clk) disable iff (!rstn)
		wb_valid && wb_op == OP_BOUNDS && wb_operands.dst ==
			wb_operands.lower && wb_size == SZ_LONG |=>
			flags_ff.z && !flags_ff.c;
	endproperty
	a_bounds: assert property (p_bounds)
		else $error("bounds equality not flagged");

	// Unimplemented line gives a one word trap next cycle.
	property p_trap;
		@(posedge sys_clk) disable iff (!rstn)
		op_word_valid && (op_word[15:12] == IFF_LINE_A ||
			op_word[15:12] == IFF_LINE_F) |=> trap_request
			&& decode_info.length == 3'h1 ##1 !trap_request || op_word_valid;
	endproperty
	a_trap: assert property (p_trap)
		else $error("unimplemented opcode did not trap");

	// Length is one word exactly when no extension kind is set.
	property p_length;
		@(posedge sys_clk) disable iff (!rstn)
		decode_valid |-> decode_info.length >= 3'h1 &&
			((decode_info.length == 3'h1) == (decode_info.ext == EXT_NONE));
	endproperty
	a_length: assert property (p_length)
		else $error("decoded length out of range");

	// Flags stand still without writeback or software write.
	property p_commit;
		@(posedge sys_clk) disable iff (!rstn)
		!wb_valid && !sw_flag_wr |=> $stable(result_flag_byte);
	endproperty
	a_commit: assert property (p_commit)
		else $error("flags changed without a commit");
endmodule

// [tb/iff_tb.sv]
// Self-checking bench for the flag unit: writeback, decode, register bus.
`timescale 1ns/1ps
module testbench;
	import iff_pkg::*;

	logic             sys_clk;
	logic             rstn;
	logic [15:0]      op_word;
	logic             op_word_valid;
	logic             wb_valid;
	iff_op_type       wb_op;
	iff_size_type     wb_size;
	iff_operands_type wb_operands;
	logic             wb_signed;
	logic [31:0]      wb_product_high;
	logic             wb_decimal_carry;
	logic             wb_div_overflow;
	logic [3:0]       avs_address;
	logic             avs_read;
	logic             avs_write;
	logic [31:0]      avs_writedata;
	logic [3:0]       avs_byteenable;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic [7:0]       result_flag_byte;
	iff_decode_type   decode_info;
	logic             decode_valid;
	logic             trap_request;
	logic [31:0]      lo, up, ph, q;
	logic             sg, dc, dv;
	int               bad_count;
	int               n_tests;

	iff_flag_unit dut (
		.sys_clk(sys_clk), .rstn(rstn), .op_word(op_word),
		.op_word_valid(op_word_valid), .wb_valid(wb_valid), .wb_op(wb_op),
		.wb_size(wb_size), .wb_operands(wb_operands),
		.wb_signed(wb_signed), .wb_product_high(wb_product_high),
		.wb_decimal_carry(wb_decimal_carry),
		.wb_div_overflow(wb_div_overflow), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.result_flag_byte(result_flag_byte), .decode_info(decode_info),
		.decode_valid(decode_valid), .trap_request(trap_request)
	);

	// Clock of 8 ns period.
	always #4 sys_clk = ~sys_clk;

	// Prints the verdict and ends the run.
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Compare tasks for flag bytes, bus words and single bits.
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp1(input logic g, input logic e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One bus access; held until waitrequest is seen low at an edge.
	task automatic av(input logic r, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		int k;
		@(posedge sys_clk);
		avs_read <= r;
		avs_write <= !r;
		avs_address <= a;
		avs_writedata <= wd;
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		d = avs_readdata;
		if (k >= 50)
			bad_count++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] wd);
		logic [31:0] d;
		av(1'b0, a, wd, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		av(1'b1, a, 32'h0, d);
		cmp32(d, e);
	endtask

	// One writeback strobe; the new flags must show in the next cycle.
	task automatic wb(input iff_op_type op, input iff_size_type sz,
		input logic [31:0] s, input logic [31:0] d, input logic [31:0] r,
		input logic [4:0] e);
		@(posedge sys_clk);
		wb_valid <= 1'b1;
		wb_op <= op;
		wb_size <= sz;
		wb_operands <= '{s, d, r, lo, up};
		wb_signed <= sg;
		wb_product_high <= ph;
		wb_decimal_carry <= dc;
		wb_div_overflow <= dv;
		@(posedge sys_clk);
		wb_valid <= 1'b0;
		#1;
		cmp8(result_flag_byte, {3'h0, e});
	endtask

	// One operation word; decode and trap answer one cycle later.
	task automatic dec(input logic [15:0] w, input logic t);
		@(posedge sys_clk);
		op_word <= w;
		op_word_valid <= 1'b1;
		@(posedge sys_clk);
		op_word_valid <= 1'b0;
		#1;
		cmp1(decode_valid, 1'b1);
		cmp1(trap_request, t);
		cmp1(decode_info.length != 3'h0, 1'b1);
		@(posedge sys_clk);
		#1;
		cmp1(trap_request, 1'b0);
	endtask

	// Watchdog that cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end

	// Main sequence of tests.
	initial
	begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		op_word = 16'h0000;
		op_word_valid = 1'b0;
		wb_valid = 1'b0;
		wb_op = OP_NONE;
		wb_size = SZ_BYTE;
		wb_operands = '0;
		wb_signed = 1'b0;
		wb_product_high = 32'h0;
		wb_decimal_carry = 1'b0;
		wb_div_overflow = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		{lo, up, ph, sg, dc, dv} = '0;
		bad_count = 0;
		n_tests = 0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		cmp8(result_flag_byte, 8'h00);
		cmp1(avs_waitrequest, 1'b1);
		wr(4'h0, 32'h0000001F);
		rd(4'h0, 32'h0000001F);
		wr(4'hC, 32'h00000000);
		rd(4'h8, 32'h00000000);
		rd(4'h0, 32'h0000001F);
		wb(OP_LOGIC, SZ_BYTE, 32'h0, 32'h0, 32'h00000080, 5'h18);
		wb(OP_LOGIC, SZ_WORD, 32'h0, 32'h0, 32'hFFFF0000, 5'h14);
		wb(OP_ADD, SZ_BYTE, 32'h7F, 32'h01, 32'h80, 5'h0A);
		wb(OP_ADD, SZ_BYTE, 32'hFF, 32'h01, 32'h100, 5'h15);
		wb(OP_ADD, SZ_LONG, 32'h80000000, 32'h80000000, 32'h0, 5'h17);
		wb(OP_SUB, SZ_BYTE, 32'h01, 32'h00, 32'hFF, 5'h19);
		wb(OP_SUB, SZ_WORD, 32'h0001, 32'h8000, 32'h7FFF, 5'h02);
		wr(4'h0, 32'h00000010);
		wb(OP_CMP, SZ_WORD, 32'h1, 32'h1, 32'h0, 5'h14);
		wb(OP_CMP, SZ_BYTE, 32'h01, 32'h00, 32'hFF, 5'h19);
		wr(4'h0, 32'h00000004);
		wb(OP_ADD_WITH_EXTEND_OP, SZ_LONG, 32'h0, 32'h0, 32'h0, 5'h04);
		wb(OP_ADD_WITH_EXTEND_OP, SZ_BYTE, 32'h0, 32'h0, 32'h1, 5'h00);
		wb(OP_ADD_WITH_EXTEND_OP, SZ_BYTE, 32'h0, 32'h0, 32'h0, 5'h00);
		wr(4'h0, 32'h00000004);
		wb(OP_SUBTRACT_WITH_EXTEND_OP, SZ_BYTE, 32'h01, 32'h00, 32'hFF, 5'h19);
		wr(4'h0, 32'h00000004);
		wb(OP_NEGATE_WITH_EXTEND_OP, SZ_BYTE, 32'h0, 32'h0, 32'h0, 5'h04);
		wb(OP_NEG, SZ_BYTE, 32'h0, 32'h01, 32'hFF, 5'h19);
		wr(4'h0, 32'h0000000E);
		dc = 1'b1;
		wb(OP_DECIMAL, SZ_BYTE, 32'h0, 32'h0, 32'h01, 5'h1B);
		dc = 1'b0;
		wb(OP_DECIMAL, SZ_BYTE, 32'h0, 32'h0, 32'h00, 5'h0A);
		wr(4'h0, 32'h0000001F);
		dv = 1'b1;
		wb(OP_DIV, SZ_WORD, 32'h0, 32'h0, 32'h0, 5'h16);
		dv = 1'b0;
		wb(OP_DIV, SZ_WORD, 32'h0, 32'h0, 32'h8000, 5'h18);
		wr(4'h0, 32'h00000011);
		ph = 32'h1;
		wb(OP_MUL, SZ_LONG, 32'h0, 32'h0, 32'h1, 5'h12);
		sg = 1'b1;
		ph = 32'hFFFFFFFF;
		wb(OP_MUL, SZ_LONG, 32'h0, 32'h0, 32'h80000000, 5'h18);
		ph = 32'h0;
		wb(OP_MUL, SZ_LONG, 32'h0, 32'h0, 32'h80000000, 5'h1A);
		sg = 1'b0;
		wr(4'h0, 32'h0000000A);
		lo = 32'h10;
		up = 32'h20;
		wb(OP_BOUNDS, SZ_BYTE, 32'h0, 32'h20, 32'h0, 5'h0E);
		wb(OP_BOUNDS, SZ_BYTE, 32'h0, 32'h30, 32'h0, 5'h0B);
		wb(OP_BOUNDS, SZ_BYTE, 32'h0, 32'h10, 32'h0, 5'h0E);
		lo = 32'h30;
		up = 32'h10;
		wb(OP_BOUNDS, SZ_BYTE, 32'h0, 32'h20, 32'h0, 5'h0B);
		wb(OP_BOUNDS, SZ_LONG, 32'h0, 32'h30, 32'h0, 5'h0E);
		wb(OP_BOUNDS, SZ_BYTE, 32'h0, 32'h05, 32'h0, 5'h0A);
		wb(OP_NONE, SZ_BYTE, 32'hFF, 32'hFF, 32'h0, 5'h0A);
		rd(4'h0, 32'h0000000A);
		dec(16'h7E00, 1'b0);
		cmp8({5'h0, decode_info.reg_num}, 8'h07);
		cmp8({6'h0, decode_info.loc}, {6'h0, LOC_REG_FIELD});
		dec(16'h6000, 1'b0);
		cmp8({5'h0, decode_info.ext}, {5'h0, EXT_BRANCH});
		cmp8({5'h0, decode_info.length}, 8'h02);
		cmp8({6'h0, decode_info.loc}, {6'h0, LOC_IMPLICIT});
		dec(16'h0128, 1'b0);
		cmp8({5'h0, decode_info.ext}, {5'h0, EXT_EA});
		cmp8({5'h0, decode_info.length}, 8'h02);
		dec(16'hD0C0, 1'b0);
		cmp1(decode_info.reg_is_addr, 1'b1);
		for (int i = 0; i < 16; i++)
			dec({i[3:0], 12'h000}, i == 10 || i == 15);
		av(1'b1, 4'h4, 32'h0, q);
		cmp32({q[31:15], 15'h0}, 32'h0);
		cmp1(q[2:0] != 3'h0, 1'b1);
		complete_run();
	end
endmodule
